//--- verification/spp_ext_host.sv
// Model of the external party on the strobed port: strobes bytes in and out.
// Assumes pins with pullups and that the bench calls its tasks just after clk rises.
`timescale 1ns/1ps

module spp_ext_host (
    input  wire logic       clk,
    input  wire logic [7:0] p6_out,
    input  wire logic [7:0] p6_oe_n,
    output logic      [7:0] p6_pin,
    output logic            output_strobe_n,
    output logic            input_strobe_n,
    input  wire logic       a_out,
    input  wire logic       a_oe_n,
    output logic            a_pin,
    input  wire logic       b_out,
    input  wire logic       b_oe_n,
    output logic            b_pin
);
    logic       drv_r;
    logic [7:0] dat_r;
    logic [1:0] a_r;
    logic [1:0] b_r;

    initial begin
        drv_r = 1'b0;
        dat_r = 8'h00;
        a_r = 2'h0;
        b_r = 2'h0;
        output_strobe_n = 1'b1;
        input_strobe_n = 1'b1;
    end

    // Released lines fall back to the pullup level, never to a stale value
    assign p6_pin = (~p6_oe_n & p6_out) | (p6_oe_n & (drv_r ? dat_r : 8'hff));
    assign a_pin  = !a_oe_n ? a_out : (a_r[1] ? a_r[0] : 1'b1);
    assign b_pin  = !b_oe_n ? b_out : (b_r[1] ? b_r[0] : 1'b1);

    // Each flag argument: bit 1 drives the pin, bit 0 is the level
    task automatic flags(input logic [1:0] a, input logic [1:0] b);
        a_r = a;
        b_r = b;
    endtask : flags

    task automatic in_low(input logic [7:0] d);
        drv_r = 1'b1;
        dat_r = d;
        input_strobe_n = 1'b0;
    endtask : in_low

    // Data is held well past the rising edge so the synchronised capture sees it
    task automatic in_high();
        input_strobe_n = 1'b1;
        repeat (5) @(posedge clk);
        #1 drv_r = 1'b0;
    endtask : in_high

    task automatic out_strobe(input logic lvl);
        output_strobe_n = lvl;
    endtask : out_strobe
endmodule : spp_ext_host

//--- verification/spp_port_tb.sv
// Self-checking bench for the strobed parallel port, CPU side and pin side.
// Assumes the design package and spp_ext_host are compiled first.
`timescale 1ns/1ps

module spp_port_tb;
    import spp_pkg::*;

    logic            clk = 1'b0;
    logic            sys_rst = 1'b1;
    spp_sfr_req_type sfr_req = '0;
    logic [7:0]      sfr_rdata, rd_v;
    logic            sfr_hit;
    logic [7:0]      p4_in, p4_out, p4_oe_n, p5_in, p5_out, p5_oe_n;
    logic [7:0]      p6_in, p6_out, p6_oe_n;
    logic            ods_n, ids_n, a_in, a_out, a_oe_n, b_in, b_out, b_oe_n;
    logic [7:0]      p4_ext = 8'hff;
    logic [7:0]      p5_ext = 8'hff;
    int              fails = 0;
    int              n_tests = 0;

    always #10 clk = ~clk;
    // Released pins sit at the pullup unless the far side pulls them low
    assign p4_in = ((~p4_oe_n & p4_out) | p4_oe_n) & p4_ext;
    assign p5_in = ((~p5_oe_n & p5_out) | p5_oe_n) & p5_ext;

    spp_port #(.P4_WIDTH(8)) u_dut (
        .clk(clk), .sys_rst(sys_rst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
        .sfr_hit(sfr_hit), .p4_in(p4_in), .p4_out(p4_out), .p4_oe_n(p4_oe_n),
        .p5_in(p5_in), .p5_out(p5_out), .p5_oe_n(p5_oe_n), .p6_in(p6_in),
        .p6_out(p6_out), .p6_oe_n(p6_oe_n), .output_strobe_n(ods_n),
        .input_strobe_n(ids_n), .out_side_flag_pin_in(a_in),
        .out_side_flag_pin_out(a_out), .out_side_flag_pin_oe_n(a_oe_n),
        .in_side_flag_pin_in(b_in), .in_side_flag_pin_out(b_out),
        .in_side_flag_pin_oe_n(b_oe_n)
    );

    spp_ext_host u_host (
        .clk(clk), .p6_out(p6_out), .p6_oe_n(p6_oe_n), .p6_pin(p6_in),
        .output_strobe_n(ods_n), .input_strobe_n(ids_n), .a_out(a_out),
        .a_oe_n(a_oe_n), .a_pin(a_in), .b_out(b_out), .b_oe_n(b_oe_n), .b_pin(b_in)
    );

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        tick(1);
        sfr_req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        tick(1);
        sfr_req.wr = 1'b0;
    endtask : sfr_wr

    task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
        int i;
        tick(1);
        sfr_req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        tick(1);
        sfr_req.rd = 1'b0;
        for (i = 0; i < 4 && sfr_hit !== 1'b1; i++) begin
            tick(1);
        end
        if (sfr_hit !== 1'b1) begin
            fails++;
            $display("[FAIL] %0t no read answer", $time);
            tally_and_finish();
        end
        d = sfr_rdata;
    endtask : sfr_rd

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        sfr_rd(a, rd_v);
        check(what, rd_v, exp);
    endtask : rd_chk

    task automatic t_reset();
        rd_chk("csr reset", 8'he8, 8'hfc);
        check("p4 released", p4_oe_n, 8'hff);
        check("p6 floats", p6_oe_n, 8'hff);
        sfr_wr(8'hc0, 8'h0f);
        check("p4 drives zeros", p4_oe_n, 8'h0f);
        check("p4 latch out", p4_out, 8'h0f);
        tick(3);
        rd_chk("p4 pins", 8'hc0, 8'h0f);
        rd_chk("p5 pins", 8'hc8, 8'hff);
        p4_ext = 8'hfa;
        sfr_wr(8'hc8, 8'h3c);
        check("p5 drives zeros", p5_oe_n, 8'h3c);
        check("p5 latch out", p5_out, 8'h3c);
        p5_ext = 8'hf7;
        tick(3);
        rd_chk("p4 pulled low", 8'hc0, 8'h0a);
        rd_chk("p5 pulled low", 8'hc8, 8'h34);
        p4_ext = 8'hff;
        p5_ext = 8'hff;
        sfr_wr(8'hc0, 8'hff);
        sfr_wr(8'he8, 8'hff);
        rd_chk("csr ro bits", 8'he8, 8'hfc);
        sfr_wr(8'he8, 8'h03);
        rd_chk("csr clear", 8'he8, 8'h00);
        rd_chk("unmapped", 8'h55, 8'h00);
        $display("test reset done");
    endtask : t_reset

    task automatic t_flags();
        for (int m = 0; m < 2; m++) begin
            sfr_wr(8'he8, m[0] ? 8'h50 : 8'h00);
            check("a level", {a_oe_n, a_out}, {1'b0, m[0]});
            check("b level", {b_oe_n, b_out}, {1'b0, m[0]});
        end
        sfr_wr(8'hd8, 8'h0f);
        check("plain io", p6_oe_n, 8'h0f);
        check("plain pins", p6_in, 8'h0f);
        $display("test flags done");
    endtask : t_flags

    task automatic t_input();
        rd_chk("drain", 8'hd8, 8'h00);
        sfr_wr(8'he8, 8'h80);
        u_host.in_low(8'h5a);
        tick(6);
        rd_chk("no flag while low", 8'he8, 8'h82);
        u_host.in_high();
        check("b shows full", b_out, 8'h01);
        rd_chk("captured", 8'hd8, 8'h5a);
        rd_chk("read clears", 8'he8, 8'h82);
        sfr_wr(8'he8, 8'h84);
        u_host.in_low(8'ha5);
        tick(6);
        rd_chk("flag on fall", 8'he8, 8'h87);
        rd_chk("transparent", 8'hd8, 8'ha5);
        u_host.in_high();
        tick(4);
        rd_chk("held high", 8'hd8, 8'ha5);
        $display("test input done");
    endtask : t_input

    task automatic t_output();
        sfr_wr(8'he8, 8'h28);
        sfr_wr(8'hd8, 8'h3c);
        check("always drives", p6_oe_n, 8'h00);
        check("always data", p6_in, 8'h3c);
        check("a shows full", a_out, 8'h01);
        rd_chk("full set", 8'he8, 8'h2a);
        u_host.out_strobe(1'b0);
        tick(6);
        check("rise clears only", a_out, 8'h01);
        u_host.out_strobe(1'b1);
        tick(6);
        check("cleared on rise", a_out, 8'h00);
        sfr_wr(8'he8, 8'h20);
        sfr_wr(8'hd8, 8'h11);
        u_host.out_strobe(1'b0);
        tick(6);
        check("cleared on fall", a_out, 8'h00);
        u_host.out_strobe(1'b1);
        $display("test output done");
    endtask : t_output

    task automatic t_handshake();
        u_host.flags(2'b00, 2'b10);
        sfr_wr(8'he8, 8'hc8);
        sfr_wr(8'hd8, 8'h99);
        tick(6);
        check("idle floats", p6_oe_n, 8'hff);
        u_host.out_strobe(1'b0);
        tick(6);
        check("strobe drives", p6_oe_n, 8'h00);
        check("strobe data", p6_in, 8'h99);
        u_host.flags(2'b00, 2'b11);
        tick(6);
        check("disabled floats", p6_oe_n, 8'hff);
        u_host.flags(2'b11, 2'b10);
        sfr_wr(8'he8, 8'hf8);
        tick(6);
        check("select status", p6_in, 8'hfa);
        u_host.flags(2'b10, 2'b10);
        tick(6);
        check("select data", p6_in, 8'h99);
        u_host.out_strobe(1'b1);
        tick(6);
        rd_chk("cleared by strobe", 8'he8, 8'hf8);
        $display("test handshake done");
    endtask : t_handshake

    initial begin
        tick(20);
        sys_rst = 1'b0;
        t_reset();
        t_flags();
        t_input();
        t_output();
        t_handshake();
        tally_and_finish();
    end
endmodule : spp_port_tb

//--- verilog/spp_pkg.sv
// Types shared by the strobed parallel port design.
// Assumes spp_regs.svh is on the include path.
`include "spp_regs.svh"

package spp_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } spp_sfr_req_type;

    typedef struct packed {
        logic [1:0] mb;
        logic [1:0] ma;
        logic       oclr;
        logic       isel;
    } spp_ctrl_type;

    typedef enum logic [1:0] {
        SPP_IN_IDLE,
        SPP_IN_OPEN,
        SPP_IN_HOLD
    } spp_in_state_type;

endpackage : spp_pkg

//--- verilog/spp_port.sv
// Contract
// - Simple port pins written one are released to pullup and read as inputs.
// - Simple port latches sit at SFR addresses c0 and c8.
// - Strobed data register at d8, control/status register at e8.
// - Control bits 2..7 read/write, bits 0..1 read-only; reset 1s and 0s.
// - Input-full flag sets on the selected strobe edge, clears on CPU read of data.
// - Output-full flag sets whenever the CPU writes the data register.
// - Edge select zero: load buffer and set input-full on strobe rising edge.
// - Edge select one: flag on falling edge, transparent low, held high.
// - Clear-edge bit picks output strobe edge clearing output-full: 1 rise, 0 fall.
// - Bits 5:4 set first flag pin: low, high, output-full, select input.
// - Select input low outputs data register, high outputs control/status.
// - Bits 7:6 set second flag pin: low, high, input-full, enable input.
// - Enable input high floats drivers and ignores input strobe; low enables.
// - Outside output-always and plain I/O modes drivers are on only while output strobe low.
// - Bit7=0, bits5:4=10: drive always; output strobe only clears output-full.
// - Port also works as plain unhandshaked I/O selected by control settings.
//
// Strobed parallel port with two simple ports, reached through CPU SFR accesses.
// Assumes sfr requests come from clk logic; all pins are asynchronous to clk.
`timescale 1ns/1ps

module spp_port
    import spp_pkg::*;
#(
    parameter int P4_WIDTH = 8
) (
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire spp_sfr_req_type      sfr_req,
    output logic [7:0]                sfr_rdata,
    output logic                      sfr_hit,
    input  wire logic [P4_WIDTH-1:0]  p4_in,
    output logic [P4_WIDTH-1:0]       p4_out,
    output logic [P4_WIDTH-1:0]       p4_oe_n,
    input  wire logic [7:0]           p5_in,
    output logic [7:0]                p5_out,
    output logic [7:0]                p5_oe_n,
    input  wire logic [7:0]           p6_in,
    output logic [7:0]                p6_out,
    output logic [7:0]                p6_oe_n,
    input  wire logic                 output_strobe_n,
    input  wire logic                 input_strobe_n,
    input  wire logic                 out_side_flag_pin_in,
    output logic                      out_side_flag_pin_out,
    output logic                      out_side_flag_pin_oe_n,
    input  wire logic                 in_side_flag_pin_in,
    output logic                      in_side_flag_pin_out,
    output logic                      in_side_flag_pin_oe_n
);
    // Synchronisers: stage one feeds stage two only
    logic [P4_WIDTH-1:0] p4_s1_r, p4_s2_r;
    logic [7:0]          p5_s1_r, p5_s2_r;
    logic [7:0]          p6_s1_r, p6_s2_r;
    logic [3:0]          pin_s1_r, pin_s2_r;
    logic                ods_d_r, ids_d_r;

    logic [P4_WIDTH-1:0] p4_latch_r;
    logic [7:0]          p5_latch_r;
    logic [7:0]          out_data_r;
    logic [7:0]          in_buf_r;
    spp_ctrl_type        ctrl_r;
    logic                ibf_r;
    logic                obf_r;
    spp_in_state_type    in_state_r;
    logic [7:0]          rdata_r;
    logic                hit_r;

    logic ods_s, ids_s, sel_s, pe_s;
    logic ods_rise, ods_fall, ids_rise, ids_fall;
    logic pe_mode, sel_mode, out_always, port_on;
    logic capture, ibf_set, ibf_clr, obf_set, obf_clr, in_open;
    logic [7:0] csr_view, p6_src;
    logic       cap_valid, cap_ready, buf_valid, buf_ready;
    logic [7:0] buf_data;
    logic [5:0] ctrl_wr_bits;

    function automatic logic is_addr(input logic [7:0] a, input logic [7:0] b);
        is_addr = (a == b);
    endfunction : is_addr

    function automatic logic flag_drive(input logic [1:0] m, input logic st);
        case (m)
            `SPP_FLAG_LOW:    flag_drive = 1'b0;
            `SPP_FLAG_HIGH:   flag_drive = 1'b1;
            `SPP_FLAG_STATUS: flag_drive = st;
            default:          flag_drive = 1'b1;
        endcase
    endfunction : flag_drive

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            p4_s1_r  <= '1;
            p4_s2_r  <= '1;
            p5_s1_r  <= '1;
            p5_s2_r  <= '1;
            p6_s1_r  <= '1;
            p6_s2_r  <= '1;
            pin_s1_r <= '1;
            pin_s2_r <= '1;
            ods_d_r  <= 1'b1;
            ids_d_r  <= 1'b1;
        end else begin
            p4_s1_r  <= p4_in;
            p4_s2_r  <= p4_s1_r;
            p5_s1_r  <= p5_in;
            p5_s2_r  <= p5_s1_r;
            p6_s1_r  <= p6_in;
            p6_s2_r  <= p6_s1_r;
            pin_s1_r <= {output_strobe_n, input_strobe_n,
                         out_side_flag_pin_in, in_side_flag_pin_in};
            pin_s2_r <= pin_s1_r;
            ods_d_r  <= pin_s2_r[3];
            ids_d_r  <= pin_s2_r[2];
        end
    end

    assign ods_s      = pin_s2_r[3];
    assign ids_s      = pin_s2_r[2];
    assign sel_s      = pin_s2_r[1];
    assign pe_s       = pin_s2_r[0];
    assign ods_rise   = ods_s && !ods_d_r;
    assign ods_fall   = !ods_s && ods_d_r;
    assign ids_rise   = ids_s && !ids_d_r;
    assign ids_fall   = !ids_s && ids_d_r;

    assign pe_mode    = (ctrl_r.mb == `SPP_FLAG_INPUT);
    assign sel_mode   = (ctrl_r.ma == `SPP_FLAG_INPUT);
    assign out_always = !ctrl_r.mb[1] && (ctrl_r.ma == `SPP_FLAG_STATUS);
    assign port_on    = !(pe_mode && pe_s);

    // Flag set follows the selected strobe edge; capture always uses the rising edge
    assign ibf_set = port_on && (ctrl_r.isel ? ids_fall : ids_rise);
    assign capture = port_on && ids_rise;
    assign in_open = (in_state_r == SPP_IN_OPEN);
    assign ibf_clr = sfr_req.rd && is_addr(sfr_req.addr, `SPP_ADDR_DATA);
    assign obf_set = sfr_req.wr && is_addr(sfr_req.addr, `SPP_ADDR_DATA);
    assign obf_clr = (out_always || port_on) &&
                     (ctrl_r.oclr ? ods_rise : ods_fall);

    // Captured bytes pass the two-entry buffer before the input register;
    // its output is always accepted, so each byte lands one cycle later.
    assign cap_valid = capture;
    assign buf_ready = 1'b1;

    spp_skid #(
        .WIDTH (8),
        .DEPTH (2)
    ) u_skid (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (cap_valid),
        .in_ready  (cap_ready),
        .in_data   (p6_s2_r),
        .out_valid (buf_valid),
        .out_ready (buf_ready),
        .out_data  (buf_data)
    );

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            in_state_r <= SPP_IN_IDLE;
        else begin
            case (in_state_r)
                SPP_IN_IDLE: begin
                    if (ctrl_r.isel && port_on && !ids_s)
                        in_state_r <= SPP_IN_OPEN;
                end
                SPP_IN_OPEN: begin
                    if (ids_s || !ctrl_r.isel || !port_on)
                        in_state_r <= SPP_IN_HOLD;
                end
                SPP_IN_HOLD:
                    in_state_r <= SPP_IN_IDLE;
                default:
                    in_state_r <= SPP_IN_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            in_buf_r <= '0;
        else if (in_open)
            in_buf_r <= p6_s2_r;
        else if (buf_valid)
            in_buf_r <= buf_data;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            ibf_r <= 1'b0;
        else if (ibf_set)
            ibf_r <= 1'b1;
        else if (ibf_clr)
            ibf_r <= 1'b0;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            obf_r <= 1'b0;
        else if (obf_set)
            obf_r <= 1'b1;
        else if (obf_clr)
            obf_r <= 1'b0;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            ctrl_r <= spp_ctrl_type'(`SPP_CSR_CTRL_RST);
        else if (sfr_req.wr && is_addr(sfr_req.addr, `SPP_ADDR_CSR))
            ctrl_r <= spp_ctrl_type'(sfr_req.wdata[7:2]);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            p4_latch_r <= '1;
            p5_latch_r <= `SPP_LATCH_RST;
            out_data_r <= `SPP_LATCH_RST;
        end else if (sfr_req.wr) begin
            if (is_addr(sfr_req.addr, `SPP_ADDR_P4))
                p4_latch_r <= sfr_req.wdata[P4_WIDTH-1:0];
            if (is_addr(sfr_req.addr, `SPP_ADDR_P5))
                p5_latch_r <= sfr_req.wdata;
            if (is_addr(sfr_req.addr, `SPP_ADDR_DATA))
                out_data_r <= sfr_req.wdata;
        end
    end

    assign csr_view = {ctrl_r, obf_r, ibf_r};
    assign ctrl_wr_bits = sfr_req.wdata[7:2];

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_r <= '0;
            hit_r   <= 1'b0;
        end else begin
            hit_r   <= sfr_req.rd;
            rdata_r <= '0;
            if (sfr_req.rd) begin
                case (sfr_req.addr)
                    `SPP_ADDR_P4:   rdata_r <= 8'(p4_s2_r);
                    `SPP_ADDR_P5:   rdata_r <= p5_s2_r;
                    `SPP_ADDR_DATA: rdata_r <= in_buf_r;
                    `SPP_ADDR_CSR:  rdata_r <= csr_view;
                    default:        rdata_r <= '0;
                endcase
            end
        end
    end

    assign sfr_rdata = rdata_r;
    assign sfr_hit   = hit_r;

    // Quasi-bidirectional: a one releases the pin to its pullup
    assign p4_out  = p4_latch_r;
    assign p4_oe_n = p4_latch_r;
    assign p5_out  = p5_latch_r;
    assign p5_oe_n = p5_latch_r;

    // Sources: data register unless select input reads high
    assign p6_src  = (sel_mode && sel_s) ? csr_view : out_data_r;
    assign p6_out  = p6_src;
    // Output-always drives always, others under the strobe; plain I/O keeps quasi-bidir while strobe high
    always_comb begin
        if (out_always)
            p6_oe_n = '0;
        else if (port_on && !ods_s)
            p6_oe_n = '0;
        else if (ctrl_r.ma == `SPP_FLAG_HIGH && ctrl_r.mb == `SPP_FLAG_HIGH)
            p6_oe_n = out_data_r;
        else
            p6_oe_n = '1;
    end

    assign out_side_flag_pin_out  = flag_drive(ctrl_r.ma, obf_r);
    assign out_side_flag_pin_oe_n = sel_mode;
    assign in_side_flag_pin_out   = flag_drive(ctrl_r.mb, ibf_r);
    assign in_side_flag_pin_oe_n  = pe_mode;

    // Flags: a set in the same cycle as a clear wins, so no event is lost
    AST_OBF_SET: assert property (@(posedge clk) disable iff (sys_rst)
        obf_set |=> obf_r)
        else $error("output-full not set after data write");
    AST_IBF_CLR: assert property (@(posedge clk) disable iff (sys_rst)
        (ibf_clr && !ibf_set) |=> !ibf_r)
        else $error("input-full not cleared");
    AST_IBF_EDGE: assert property (@(posedge clk) disable iff (sys_rst)
        (!ctrl_r.isel && ids_rise && port_on) |=> ibf_r)
        else $error("rising strobe did not set input-full");
    AST_IBF_FALL: assert property (@(posedge clk) disable iff (sys_rst)
        (ctrl_r.isel && ids_fall && port_on) |=> ibf_r)
        else $error("falling strobe did not set input-full");
    AST_PE_IGNORE: assert property (@(posedge clk) disable iff (sys_rst)
        (pe_mode && pe_s && !ibf_r) |=> !ibf_r)
        else $error("input strobe acted while port disabled");

    sequence s_obf_fall_clear;
        !ctrl_r.oclr && port_on && ods_fall && !obf_set;
    endsequence
    sequence s_obf_rise_clear;
        ctrl_r.oclr && port_on && ods_rise && !obf_set;
    endsequence
    AST_OBF_CLR: assert property (@(posedge clk) disable iff (sys_rst)
        s_obf_fall_clear |=> !obf_r)
        else $error("falling strobe did not clear");
    AST_OBF_RISE: assert property (@(posedge clk) disable iff (sys_rst)
        s_obf_rise_clear |=> !obf_r)
        else $error("rising strobe did not clear");

    // A rising-edge byte spends one cycle in the buffer before the register
    sequence s_ids_capture;
        !ctrl_r.isel && port_on && ids_rise && (in_state_r == SPP_IN_IDLE);
    endsequence
    AST_CAPTURE: assert property (@(posedge clk) disable iff (sys_rst)
        s_ids_capture |=> ##1 (in_buf_r == $past(p6_s2_r, 2)))
        else $error("strobed byte not in input register");
    AST_TRANSP: assert property (@(posedge clk) disable iff (sys_rst)
        in_open |=> (in_buf_r == $past(p6_s2_r)))
        else $error("input register not transparent while strobe low");

    // Driver enables for each mode
    AST_ALWAYS: assert property (@(posedge clk) disable iff (sys_rst)
        out_always |-> p6_oe_n == 8'h00)
        else $error("output-always not driving");
    AST_STROBE_DRV: assert property (@(posedge clk) disable iff (sys_rst)
        (port_on && !ods_s) |-> p6_oe_n == 8'h00)
        else $error("drivers off while output strobe low");
    AST_STROBE_OFF: assert property (@(posedge clk) disable iff (sys_rst)
        (!out_always && ods_s && !(ctrl_r.ma == `SPP_FLAG_HIGH &&
                                   ctrl_r.mb == `SPP_FLAG_HIGH)) |-> p6_oe_n == 8'hff)
        else $error("drivers on without output strobe");
    AST_PE_OFF: assert property (@(posedge clk) disable iff (sys_rst)
        (pe_mode && pe_s && !out_always) |-> p6_oe_n == 8'hff)
        else $error("drivers on while port disabled");
    AST_PLAIN_IO: assert property (@(posedge clk) disable iff (sys_rst)
        (ctrl_r.ma == `SPP_FLAG_HIGH && ctrl_r.mb == `SPP_FLAG_HIGH && ods_s)
            |-> p6_oe_n == out_data_r)
        else $error("plain I/O enables do not follow data");

    AST_SEL: assert property (@(posedge clk) disable iff (sys_rst)
        (sel_mode && sel_s) |-> p6_out == csr_view)
        else $error("select wrong source");
    AST_DATA_SRC: assert property (@(posedge clk) disable iff (sys_rst)
        (sel_mode && !sel_s) |-> p6_out == out_data_r)
        else $error("select low not showing data register");
    AST_FLAGA: assert property (@(posedge clk) disable iff (sys_rst)
        (ctrl_r.ma == `SPP_FLAG_STATUS)
            |-> (out_side_flag_pin_out == obf_r && !out_side_flag_pin_oe_n))
        else $error("first flag pin not showing output-full");
    AST_FLAGB: assert property (@(posedge clk) disable iff (sys_rst)
        (ctrl_r.mb == `SPP_FLAG_STATUS) |-> in_side_flag_pin_out == ibf_r)
        else $error("second flag pin not showing input-full");

    AST_CTRL_WR: assert property (@(posedge clk) disable iff (sys_rst)
        (sfr_req.wr && is_addr(sfr_req.addr, `SPP_ADDR_CSR))
            |=> (ctrl_r == spp_ctrl_type'($past(ctrl_wr_bits))))
        else $error("control bits not written");
    AST_RD_HIT: assert property (@(posedge clk) disable iff (sys_rst)
        sfr_req.rd |=> sfr_hit)
        else $error("read not answered");
endmodule : spp_port

//--- verilog/spp_regs.svh
// Register map, field positions, reset values and codes for the strobed port.
// Included by the package, ahead of the design; holds definitions only.
`ifndef SPP_REGS_SVH
`define SPP_REGS_SVH

`define SPP_ADDR_P4         8'hc0
`define SPP_ADDR_P5         8'hc8
`define SPP_ADDR_DATA       8'hd8
`define SPP_ADDR_CSR        8'he8
`define SPP_CSR_IBF         0
`define SPP_CSR_OBF         1
`define SPP_CSR_ISEL        2
`define SPP_CSR_OCLR        3
`define SPP_CSR_MA0         4
`define SPP_CSR_MA1         5
`define SPP_CSR_MB0         6
`define SPP_CSR_MB1         7
`define SPP_CSR_CTRL_RST    6'h3f
`define SPP_LATCH_RST       8'hff
`define SPP_FLAG_LOW        2'h0
`define SPP_FLAG_HIGH       2'h1
`define SPP_FLAG_STATUS     2'h2
`define SPP_FLAG_INPUT      2'h3

`endif

//--- verilog/spp_skid.sv
// Two-entry buffer with valid/ready on both sides.
// Assumes one clock and an active-high asynchronous reset.
`timescale 1ns/1ps

module spp_skid
    import spp_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    rp_r;
    logic [AW:0]      cnt_r;
    logic             push;
    logic             pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction : bump

    assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rp_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push)
                wp_r <= bump(wp_r);
            if (pop)
                rp_r <= bump(rp_r);
            if (push && !pop)
                cnt_r <= cnt_r + (AW+1)'(1);
            else if (pop && !push)
                cnt_r <= cnt_r - (AW+1)'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (push)
            mem_r[wp_r] <= in_data;
    end

endmodule : spp_skid
